// [logic/pvr_regs.svh]
// register map, field positions, reset values and timing of the
// process value retransmission block; definitions only
`ifndef PVR_REGS_SVH
`define PVR_REGS_SVH

// byte offsets on the AHB-Lite window (low eight address bits)
`define PVR_OFS_CONFIG 8'h00
`define PVR_OFS_UNITS 8'h04
`define PVR_OFS_FILTER 8'h08
`define PVR_OFS_LOW 8'h0c
`define PVR_OFS_HIGH 8'h10
`define PVR_OFS_STATUS 8'h14
`define PVR_OFS_MASK 8'h18
`define PVR_OFS_PV 8'h1c
`define PVR_OFS_DISPLAY 8'h20
`define PVR_OFS_RETRANS 8'h24
`define PVR_OFS_DIAG 8'h28

// CONFIG fields (lsb positions)
`define PVR_CFG_FUNCTION_LEVEL 0
`define PVR_CFG_PVSRC 1
`define PVR_CFG_SPSRC 3
`define PVR_CFG_DISP 5
`define PVR_CFG_AOTYPE 8
`define PVR_CFG_AOSRC 12
// UNITS fields
`define PVR_UN_UNIT1 0
`define PVR_UN_UNIT2 2
`define PVR_UN_DP1 4
`define PVR_UN_DP2 6
// STATUS / MASK bits
`define PVR_ST_CFGERR 0
`define PVR_ST_UPDATE 1
`define PVR_ST_RANGE 2
// DIAG fields
`define PVR_DG_DIFF 4
`define PVR_DG_RANGE 5

// reset values
`define PVR_RST_FILTER_TIME_CONSTANT 10'h005
`define PVR_RST_LOW 16'h0000
`define PVR_RST_HIGH 16'h03e8

// filter: time constant in tenths of a second, 0 .. 60 s
`define PVR_FILTER_TIME_CONSTANT_MAX 10'h258
`define PVR_SAMPLE_TENTHS 10'h001
`define PVR_FRAC 8

// output end points as 16-bit converter codes; full scale is
// 20 mA for current ranges and 10 V for voltage ranges
`define PVR_CODE_ZERO 16'h0000
`define PVR_CODE_FULL 16'hffff
`define PVR_CODE_4MA 16'h3333
`define PVR_CODE_5V 16'h7fff
`define PVR_CODE_1V 16'h1999

`define PVR_ERR_NONE 4'h0
`define PVR_ERR_INPUT_CFG 4'h3

`endif

// [logic/pvr_pkg.sv]
// types of the process value retransmission block
// assumes pvr_regs.svh for the numeric layout
`default_nettype none
package pvr_pkg;
    typedef enum logic [1:0] {
        PV_FIRST = 2'h0, PV_SECOND = 2'h1, PV_1M2 = 2'h2, PV_2M1 = 2'h3
    } pv_src_t;
    typedef enum logic [1:0] {
        SP_SINGLE = 2'h0, SP_DUAL = 2'h1, SP_REM1 = 2'h2, SP_REM2 = 2'h3
    } sp_src_t;
    typedef enum logic [2:0] {
        AO_4_20MA = 3'h0, AO_0_20MA = 3'h1, AO_0_5V = 3'h2,
        AO_1_5V = 3'h3, AO_0_10V = 3'h4
    } ao_type_t;
    typedef enum logic [2:0] {
        RS_PV1 = 3'h0, RS_PV2 = 3'h1, RS_1M2 = 3'h2, RS_2M1 = 3'h3,
        RS_SP = 3'h4, RS_MV1 = 3'h5, RS_MV2 = 3'h6, RS_DEV = 3'h7
    } ao_src_t;
    // gray along idle -> filter -> scale -> done -> idle
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_FILTER_TIME_CONSTANT = 2'b01, ST_SCALE = 2'b11, ST_DONE = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic [23:0] rem;
        logic [39:0] quo;
        logic [23:0] dvs;
        logic [5:0] cnt;
        logic busy;
        logic done;
    } div_state_t;

    typedef struct packed {
        logic function_level_full;
        pv_src_t pv_src;
        sp_src_t sp_src;
        logic [1:0] disp_mode;
        ao_type_t ao_type;
        ao_src_t ao_src;
        logic [1:0] unit1;
        logic [1:0] unit2;
        logic [1:0] dp1;
        logic [1:0] dp2;
        logic [9:0] filter_time_constant_tc;
        logic signed [15:0] ao_lo;
        logic signed [15:0] ao_hi;
        logic [2:0] status;
        logic [2:0] mask;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
        seq_state_t state;
        logic div_start;
        logic [39:0] dvd;
        logic [23:0] dvs;
        logic neg;
        logic signed [17:0] qty;
        logic signed [23:0] acc;
        logic signed [15:0] pv;
        logic signed [15:0] disp;
        logic [15:0] ao_code;
        logic [3:0] err_code;
        logic diff_active;
        logic range_bad;
        logic irq;
    } pvr_state_t;
endpackage : pvr_pkg
`default_nettype wire

// [logic/seq_divider.sv]
// unsigned restoring divider, one quotient bit per clock
// assumes the caller never starts it with a zero divisor
`default_nettype none
module seq_divider (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // request
    input wire logic start,
    input wire logic [39:0] dividend,
    input wire logic [23:0] divisor,
    // answer
    output logic done,
    output logic [39:0] quotient
);
    pvr_pkg::div_state_t s_q, s_d;
    logic [24:0] trial;

    always_comb begin
        s_d = s_q;
        trial = 25'h0;
        s_d.done = 1'b0;
        if (start) begin
            s_d.rem = 24'h0;
            s_d.quo = dividend;
            s_d.dvs = divisor;
            s_d.cnt = 6'h28;
            s_d.busy = 1'b1;
        end else if (s_q.busy) begin
            trial = {s_q.rem, s_q.quo[39]};
            if (trial >= {1'b0, s_q.dvs}) begin
                s_d.rem = 24'(trial - {1'b0, s_q.dvs});
                s_d.quo = {s_q.quo[38:0], 1'b1};
            end else begin
                s_d.rem = trial[23:0];
                s_d.quo = {s_q.quo[38:0], 1'b0};
            end
            s_d.cnt = s_q.cnt - 6'h1;
            if (s_q.cnt == 6'h1) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign done = s_q.done;
    assign quotient = s_q.quo;
endmodule : seq_divider
`default_nettype wire

// [logic/process_value_retransmission.sv]
// process value derivation, display filter and analog retransmission,
// with an AHB-Lite register slave and a level interrupt
// assumes input samples come from logic on hclk, with a one-cycle
// sample strobe; the only AHB-Lite slave, so hready is its own hreadyout
`include "pvr_regs.svh"
`default_nettype none
module process_value_retransmission (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // measured and internal quantities
    input wire logic sample_strobe,
    input wire logic [15:0] first_input_value,
    input wire logic [15:0] second_input_value,
    input wire logic [15:0] active_setpoint,
    input wire logic [15:0] output_one_power,
    input wire logic [15:0] output_two_power,
    input wire logic [2:0] fitted_output_range,
    // results
    output logic [15:0] process_value,
    output logic [15:0] display_value,
    output logic [15:0] retrans_code,
    output logic [3:0] input_config_error_code,
    output logic irq
);
    pvr_pkg::pvr_state_t s_q, s_d;
    logic div_done;
    logic [39:0] div_quo;

    function automatic logic [39:0] abs40(input logic signed [39:0] v);
        abs40 = v[39] ? 40'(-v) : v;
    endfunction : abs40

    function automatic logic signed [17:0] sx(input logic [15:0] v);
        sx = {{2{v[15]}}, v};
    endfunction : sx

    // low and high converter codes of each range
    function automatic logic [15:0] end_code(input pvr_pkg::ao_type_t t,
                                             input logic high);
        case (t)
            pvr_pkg::AO_4_20MA: end_code = high ? `PVR_CODE_FULL
                                                : `PVR_CODE_4MA;
            pvr_pkg::AO_0_20MA: end_code = high ? `PVR_CODE_FULL
                                                : `PVR_CODE_ZERO;
            pvr_pkg::AO_0_5V: end_code = high ? `PVR_CODE_5V
                                              : `PVR_CODE_ZERO;
            pvr_pkg::AO_1_5V: end_code = high ? `PVR_CODE_5V
                                              : `PVR_CODE_1V;
            default: end_code = high ? `PVR_CODE_FULL : `PVR_CODE_ZERO;
        endcase
    endfunction : end_code

    seq_divider u_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(s_q.div_start),
        .dividend(s_q.dvd),
        .divisor(s_q.dvs),
        .done(div_done),
        .quotient(div_quo)
    );

    logic is_diff, cfg_err, diff_on, take;
    logic signed [17:0] pv_raw, qty, lo_code, span_code;
    logic signed [18:0] num;
    logic signed [17:0] den;
    logic signed [25:0] delta;
    logic signed [41:0] res;
    logic [15:0] lc, hc;
    logic [2:0] ev;
    logic [31:0] rd;

    always_comb begin
        s_d = s_q;
        rd = 32'h0;
        res = 42'sh0;
        ev = 3'h0;
        s_d.div_start = 1'b0;
        take = hsel && htrans[1] && hready;

        // derived process value; control path never sees the filter
        is_diff = (s_q.pv_src == pvr_pkg::PV_1M2)
            || (s_q.pv_src == pvr_pkg::PV_2M1);
        cfg_err = is_diff && ((s_q.sp_src == pvr_pkg::SP_REM1)
            || (s_q.sp_src == pvr_pkg::SP_REM2));
        cfg_err = cfg_err || (is_diff && ((s_q.unit1 != s_q.unit2)
            || (s_q.dp1 != s_q.dp2)));
        diff_on = s_q.function_level_full && is_diff
            && (s_q.sp_src == pvr_pkg::SP_DUAL) && !cfg_err;
        if (diff_on && s_q.pv_src == pvr_pkg::PV_1M2) begin
            pv_raw = 18'(sx(first_input_value)
                - sx(second_input_value));
        end else if (diff_on) begin
            pv_raw = 18'(sx(second_input_value)
                - sx(first_input_value));
        end else if (s_q.pv_src == pvr_pkg::PV_SECOND) begin
            pv_raw = sx(second_input_value);
        end else begin
            pv_raw = sx(first_input_value);
        end
        s_d.pv = pv_raw[15:0];
        s_d.diff_active = diff_on;
        s_d.err_code = cfg_err ? `PVR_ERR_INPUT_CFG : `PVR_ERR_NONE;
        s_d.range_bad = s_q.ao_type != pvr_pkg::ao_type_t'(
            fitted_output_range);
        ev[`PVR_ST_CFGERR] = cfg_err && (s_q.err_code == `PVR_ERR_NONE);
        ev[`PVR_ST_RANGE] = s_d.range_bad && !s_q.range_bad;

        // only the first input is filtered, and only for display
        case (s_q.disp_mode)
            2'h1: s_d.disp = s_q.acc[23:`PVR_FRAC];
            2'h2: s_d.disp = second_input_value;
            default: s_d.disp = (!diff_on
                && s_q.pv_src == pvr_pkg::PV_FIRST)
                ? s_q.acc[23:`PVR_FRAC] : pv_raw[15:0];
        endcase

        case (s_q.ao_src)
            pvr_pkg::RS_PV1: qty = sx(first_input_value);
            pvr_pkg::RS_PV2: qty = sx(second_input_value);
            pvr_pkg::RS_1M2: qty = 18'(sx(first_input_value)
                - sx(second_input_value));
            pvr_pkg::RS_2M1: qty = 18'(sx(second_input_value)
                - sx(first_input_value));
            pvr_pkg::RS_SP: qty = sx(active_setpoint);
            pvr_pkg::RS_MV1: qty = sx(output_one_power);
            pvr_pkg::RS_MV2: qty = sx(output_two_power);
            default: qty = 18'(pv_raw - sx(active_setpoint));
        endcase

        // interpolation operands for the scale step
        lc = end_code(s_q.ao_type, 1'b0);
        hc = end_code(s_q.ao_type, 1'b1);
        lo_code = 18'($signed({2'b00, lc}));
        span_code = 18'($signed({2'b00, hc}) - lo_code);
        num = 19'(s_q.qty - sx(s_q.ao_lo));
        den = 18'(sx(s_q.ao_hi) - sx(s_q.ao_lo));
        delta = 26'($signed({first_input_value, 8'h00})) - 26'(s_q.acc);

        case (s_q.state)
            pvr_pkg::ST_IDLE: begin
                if (sample_strobe) begin
                    s_d.qty = qty;
                    if (s_q.filter_time_constant_tc == 10'h0) begin
                        s_d.acc = $signed({first_input_value,
                            8'h00});
                        s_d.state = pvr_pkg::ST_FILTER_TIME_CONSTANT;
                    end else begin
                        // alpha = Ts / (tau + Ts)
                        s_d.dvd = 40'(abs40(40'(delta))
                            * `PVR_SAMPLE_TENTHS);
                        s_d.dvs = 24'(s_q.filter_time_constant_tc + `PVR_SAMPLE_TENTHS);
                        s_d.neg = delta[25];
                        s_d.div_start = 1'b1;
                        s_d.state = pvr_pkg::ST_FILTER_TIME_CONSTANT;
                    end
                end
            end
            pvr_pkg::ST_FILTER_TIME_CONSTANT: begin
                if (div_done || s_q.filter_time_constant_tc == 10'h0) begin
                    if (s_q.filter_time_constant_tc != 10'h0) begin
                        s_d.acc = s_q.neg ? 24'(s_q.acc - div_quo[23:0])
                            : 24'(s_q.acc + div_quo[23:0]);
                    end
                    s_d.dvd = 40'(abs40(40'(num))
                        * abs40(40'(span_code)));
                    // a zero span is kept off the divider
                    s_d.dvs = (den == 18'sh0) ? 24'h1
                        : 24'(abs40(40'(den)));
                    s_d.neg = num[18] ^ den[17];
                    s_d.div_start = 1'b1;
                    s_d.state = pvr_pkg::ST_SCALE;
                end
            end
            pvr_pkg::ST_SCALE: begin
                if (div_done) begin
                    s_d.state = pvr_pkg::ST_DONE;
                end
            end
            pvr_pkg::ST_DONE: begin
                res = s_q.neg ? 42'(lo_code) - $signed({2'b00, div_quo})
                    : 42'(lo_code) + $signed({2'b00, div_quo});
                if (!s_q.function_level_full || s_q.range_bad) begin
                    s_d.ao_code = `PVR_CODE_ZERO;
                end else if (den == 18'sh0) begin
                    s_d.ao_code = lc;
                end else if (res < 42'(lo_code)) begin
                    s_d.ao_code = lc;
                end else if (res > 42'(hc)) begin
                    s_d.ao_code = hc;
                end else begin
                    s_d.ao_code = res[15:0];
                end
                ev[`PVR_ST_UPDATE] = 1'b1;
                s_d.state = pvr_pkg::ST_IDLE;
            end
            default: s_d.state = pvr_pkg::ST_IDLE;
        endcase

        // bus: data phase of a write commits, reads answer from flops
        s_d.hreadyout = 1'b1;
        s_d.hresp = 1'b0;
        s_d.status = s_q.status;
        if (s_q.wr_pend) begin
            case (s_q.wr_addr)
                `PVR_OFS_CONFIG: begin
                    s_d.function_level_full = hwdata[`PVR_CFG_FUNCTION_LEVEL];
                    s_d.pv_src = pvr_pkg::pv_src_t'(
                        hwdata[`PVR_CFG_PVSRC +: 2]);
                    s_d.sp_src = pvr_pkg::sp_src_t'(
                        hwdata[`PVR_CFG_SPSRC +: 2]);
                    s_d.disp_mode = hwdata[`PVR_CFG_DISP +: 2];
                    s_d.ao_type = pvr_pkg::ao_type_t'(
                        hwdata[`PVR_CFG_AOTYPE +: 3]);
                    s_d.ao_src = pvr_pkg::ao_src_t'(
                        hwdata[`PVR_CFG_AOSRC +: 3]);
                end
                `PVR_OFS_UNITS: begin
                    s_d.unit1 = hwdata[`PVR_UN_UNIT1 +: 2];
                    s_d.unit2 = hwdata[`PVR_UN_UNIT2 +: 2];
                    s_d.dp1 = hwdata[`PVR_UN_DP1 +: 2];
                    s_d.dp2 = hwdata[`PVR_UN_DP2 +: 2];
                end
                `PVR_OFS_FILTER: s_d.filter_time_constant_tc = (hwdata[9:0] > `PVR_FILTER_TIME_CONSTANT_MAX)
                    ? `PVR_FILTER_TIME_CONSTANT_MAX : hwdata[9:0];
                `PVR_OFS_LOW: s_d.ao_lo = hwdata[15:0];
                `PVR_OFS_HIGH: s_d.ao_hi = hwdata[15:0];
                `PVR_OFS_STATUS: s_d.status = s_q.status & ~hwdata[2:0];
                `PVR_OFS_MASK: s_d.mask = hwdata[2:0];
                default: ;
            endcase
        end
        // a new event wins over a clear in the same cycle
        s_d.status = s_d.status | ev;
        s_d.irq = |(s_d.status & s_d.mask);

        s_d.wr_pend = take && hwrite;
        s_d.wr_addr = haddr[7:0];
        if (take && !hwrite) begin
            case (haddr[7:0])
                `PVR_OFS_CONFIG: rd = 32'({s_q.ao_src, 1'b0, s_q.ao_type,
                    1'b0, s_q.disp_mode, s_q.sp_src, s_q.pv_src,
                    s_q.function_level_full});
                `PVR_OFS_UNITS: rd = 32'({s_q.dp2, s_q.dp1, s_q.unit2,
                    s_q.unit1});
                `PVR_OFS_FILTER: rd = 32'(s_q.filter_time_constant_tc);
                // signed fields go out zero-extended: upper half reads 0
                `PVR_OFS_LOW: rd = {16'h0000, s_q.ao_lo};
                `PVR_OFS_HIGH: rd = {16'h0000, s_q.ao_hi};
                `PVR_OFS_STATUS: rd = 32'(s_q.status);
                `PVR_OFS_MASK: rd = 32'(s_q.mask);
                `PVR_OFS_PV: rd = {16'h0000, s_q.pv};
                `PVR_OFS_DISPLAY: rd = {16'h0000, s_q.disp};
                `PVR_OFS_RETRANS: rd = 32'(s_q.ao_code);
                `PVR_OFS_DIAG: rd = 32'({s_q.range_bad, s_q.diff_active,
                    s_q.err_code});
                default: rd = 32'h0;
            endcase
        end
        s_d.hrdata = rd;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.filter_time_constant_tc <= `PVR_RST_FILTER_TIME_CONSTANT;
            s_q.ao_lo <= `PVR_RST_LOW;
            s_q.ao_hi <= `PVR_RST_HIGH;
            s_q.hreadyout <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata = s_q.hrdata;
    assign hreadyout = s_q.hreadyout;
    assign hresp = s_q.hresp;
    assign process_value = s_q.pv;
    assign display_value = s_q.disp;
    assign retrans_code = s_q.ao_code;
    assign input_config_error_code = s_q.err_code;
    assign irq = s_q.irq;
endmodule : process_value_retransmission
`default_nettype wire

// [dv/pvr_sva.sv]
// checker on the top ports of the retransmission block
// assumes hready is the block's own hreadyout on a one-slave bus
`default_nettype none
module pvr_sva (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // function
    input wire logic sample_strobe,
    input wire logic [15:0] first_input_value,
    input wire logic [15:0] process_value,
    input wire logic [15:0] retrans_code,
    input wire logic [3:0] input_config_error_code
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] s_age_q;
    logic [2:0] w_age_q;
    logic wr_seen;
    logic rd_seen;
    assign wr_seen = hsel && htrans[1] && hready && hwrite;
    assign rd_seen = hsel && htrans[1] && hready && !hwrite;
    // ages saturate so a long idle spell never wraps into a false window
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_age_q <= 7'h7f;
            w_age_q <= 3'h7;
        end else begin
            s_age_q <= sample_strobe ? 7'h00
                : s_age_q + {6'h00, s_age_q != 7'h7f};
            w_age_q <= wr_seen ? 3'h0 : w_age_q + {2'h0, w_age_q != 3'h7};
        end
    end
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    a_ready_high: assert property (hreadyout == 1'b1)
        else $error("hreadyout went low");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response other than okay");
    a_rdata_idle: assert property (!rd_seen |=> hrdata == 32'h0)
        else $error("read data outside a read data phase");
    a_rdata_upper: assert property (hrdata[31:16] == 16'h0000)
        else $error("upper read data bits set");
    a_err_legal: assert property (
        input_config_error_code inside {4'h0, 4'h3})
        else $error("illegal error code");
    a_err_after_write: assert property (
        $changed(input_config_error_code) |-> w_age_q <= 3'h3)
        else $error("error code moved without a write");
    a_err_fallback: assert property (
        input_config_error_code == 4'h3 && $past(input_config_error_code)
        == 4'h3 |-> process_value == $past(first_input_value))
        else $error("process value not first input under error");
    a_code_after_pass: assert property (
        $changed(retrans_code) |-> s_age_q <= 7'h64)
        else $error("retransmission code moved outside a pass");
endmodule : pvr_sva
bind process_value_retransmission pvr_sva i_pvr_sva (
    .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata,
    .hreadyout, .hresp, .sample_strobe, .first_input_value,
    .process_value, .retrans_code, .input_config_error_code
);
`default_nettype wire

// [dv/pvr_recorder.sv]
// far-side recorder reading the retransmitted level as a converter code
// assumes the code is a registered level on hclk
`default_nettype none
module pvr_recorder (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // level and reading
    input wire logic [15:0] level_code,
    output logic [15:0] reading
);
    timeunit 1ns;
    timeprecision 1ps;
    // one-cycle acquisition lag, like a sampled input stage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reading <= 16'h0000;
        end else begin
            reading <= level_code;
        end
    end
endmodule : pvr_recorder
`default_nettype wire

// [dv/process_value_retransmission_tb.sv]
// bench: registers, differential, errors, interrupt, retransmission, filter
// assumes the block is the only AHB-Lite slave on hclk
`include "pvr_regs.svh"
`default_nettype none
module process_value_retransmission_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rdv;
    logic [1:0] htrans = '0;
    logic strobe = 0, irq;
    logic [15:0] in1 = '0, in2 = '0, sp = '0, mv1 = '0, mv2 = '0;
    logic [15:0] pv, disp, code, seen;
    logic [2:0] fitted = '0;
    logic [3:0] err;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    int lc[5] = '{`PVR_CODE_4MA, `PVR_CODE_ZERO, `PVR_CODE_ZERO,
        `PVR_CODE_1V, `PVR_CODE_ZERO};
    int hc[5] = '{`PVR_CODE_FULL, `PVR_CODE_FULL, `PVR_CODE_5V,
        `PVR_CODE_5V, `PVR_CODE_FULL};
    int q[8] = '{150, 50, 100, -100, 25, 75, 0, 125};
    int ecfg[6] = '{'h15, 'h1d, 'h0d, 'h0d, 'h0d, 'h0c};
    int eun[6] = '{0, 0, 'h01, 'h10, 'h55, 'h55};
    int eexp[6] = '{3, 3, 3, 3, 0, 0};
    assign hready = hreadyout;
    process_value_retransmission i_process_value_retransmission (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp,
        .sample_strobe(strobe), .first_input_value(in1),
        .second_input_value(in2), .active_setpoint(sp),
        .output_one_power(mv1), .output_two_power(mv2),
        .fitted_output_range(fitted), .process_value(pv),
        .display_value(disp), .retrans_code(code),
        .input_config_error_code(err), .irq
    );
    pvr_recorder i_pvr_recorder (
        .hclk, .hresetn, .level_code(code), .reading(seen)
    );
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    // address phase, then data phase; each held until hready is seen high
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rdv = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdv, e);
    endtask : rc
    task automatic run_pass();
        int n;
        @(posedge hclk);
        strobe <= 1'b1;
        @(posedge hclk);
        strobe <= 1'b0;
        n = 0;
        while (irq !== 1'b1 && n < 200) begin
            @(posedge hclk);
            n++;
        end
        chk({31'h0, irq}, 32'h1);
        @(posedge hclk);
        wr(`PVR_OFS_STATUS, 32'h2);
    endtask : run_pass
    task automatic lim(input logic [15:0] lo, input logic [15:0] hi);
        wr(`PVR_OFS_LOW, {16'h0, lo});
        wr(`PVR_OFS_HIGH, {16'h0, hi});
    endtask : lim
    task automatic pc(input logic [31:0] cfg, input logic [15:0] a,
                      input logic [15:0] b, input logic [15:0] e);
        wr(`PVR_OFS_CONFIG, cfg);
        in1 <= a;
        in2 <= b;
        run_pass();
        chk({16'h0, seen}, {16'h0, e});
    endtask : pc
    function automatic logic [15:0] ec(int x, int lo, int hi, int t);
        longint v;
        v = lc[t] + (longint'(x - lo) * (hc[t] - lc[t])) / (hi - lo);
        v = (v < lc[t]) ? lc[t] : v;
        v = (v > hc[t]) ? hc[t] : v;
        return v[15:0];
    endfunction : ec
    initial begin
        hresetn = 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rc(`PVR_OFS_CONFIG, 32'h0);
        rc(`PVR_OFS_UNITS, 32'h0);
        rc(`PVR_OFS_FILTER, 32'h5);
        rc(`PVR_OFS_HIGH, 32'h3e8);
        rc(`PVR_OFS_STATUS, 32'h0);
        rc(8'h40, 32'h0);
        $display("test reset values done");
        in1 <= 16'h01f4;
        in2 <= 16'h00c8;
        wr(`PVR_OFS_CONFIG, 32'h0d);
        repeat (2) @(posedge hclk);
        chk({16'h0, pv}, 32'h012c);
        rc(`PVR_OFS_DIAG, 32'h10);
        wr(`PVR_OFS_CONFIG, 32'h4f);
        repeat (2) @(posedge hclk);
        chk({16'h0, pv}, 32'hfed4);
        chk({16'h0, disp}, 32'h00c8);
        for (int i = 0; i < 6; i++) begin
            wr(`PVR_OFS_CONFIG, ecfg[i]);
            wr(`PVR_OFS_UNITS, eun[i]);
            repeat (2) @(posedge hclk);
            chk({28'h0, err}, eexp[i]);
        end
        chk({16'h0, pv}, 32'h01f4);
        $display("test differential done");
        wr(`PVR_OFS_MASK, 32'h1);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h1);
        wr(`PVR_OFS_STATUS, 32'h1);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        wr(`PVR_OFS_MASK, 32'h2);
        wr(`PVR_OFS_UNITS, 32'h1);
        rc(`PVR_OFS_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(`PVR_OFS_STATUS, 32'h1);
        wr(`PVR_OFS_UNITS, 32'h0);
        $display("test interrupt done");
        wr(`PVR_OFS_FILTER, 32'h3ff);
        rc(`PVR_OFS_FILTER, 32'h258);
        wr(`PVR_OFS_FILTER, 32'h0);
        lim(16'h0, 16'h64);
        for (int t = 0; t < 5; t++) begin
            fitted <= 3'(t);
            pc(32'h1 | (t << 8), 16'h64, 16'h0, 16'(hc[t]));
            pc(32'h1 | (t << 8), 16'h0, 16'h0, 16'(lc[t]));
        end
        fitted <= 3'h1;
        pc(32'h1, 16'h32, 16'h0, 16'h0);
        fitted <= 3'h0;
        pc(32'h1, 16'h32, 16'h0, ec(50, 0, 100, 0));
        pc(32'h0, 16'h32, 16'h0, 16'h0);
        sp <= 16'h0019;
        mv1 <= 16'h004b;
        for (int s = 0; s < 8; s++) begin
            pc(32'h1 | (s << 12), 16'h96, 16'h32, ec(q[s], 0, 100, 0));
        end
        lim(16'h0064, 16'hff9c);
        pc(32'h2001, 16'h3c, 16'ha, ec(50, 100, -100, 0));
        lim(16'hff9c, 16'h0064);
        pc(32'h2001, 16'h0, 16'h64, 16'h3333);
        $display("test retransmission done");
        wr(`PVR_OFS_CONFIG, 32'h21);
        in1 <= 16'h044c;
        run_pass();
        chk({16'h0, disp}, 32'h044c);
        wr(`PVR_OFS_FILTER, 32'ha);
        in1 <= 16'h0;
        run_pass();
        chk({16'h0, disp}, 32'h03e8);
        chk({16'h0, pv}, 32'h0);
        wr(`PVR_OFS_CONFIG, 32'h3);
        repeat (2) @(posedge hclk);
        chk({16'h0, pv}, 32'h0064);
        chk({16'h0, disp}, 32'h0064);
        $display("test filter done");
        tally_and_finish();
    end
endmodule : process_value_retransmission_tb
`default_nettype wire
